// >>> core/apl_position_latch.sv
// high-speed position capture for eight axes: pin synchronisers, trigger
// routing, arm and report command handling, and one capture unit per axis
// assumes encoder counts and commands come from logic on i_clk; the
// general inputs and index pulses are asynchronous pins
`timescale 1ns/1ps
module apl_position_latch #(
    parameter int P_LAT_CYC = apl_pkg::LAT_CYC              // latency budget, cycles
) (
    input  wire logic                                       i_clk,
    input  wire logic                                       i_sys_rst,
    input  wire logic [apl_pkg::NUM_GEN_IN-1:0]             i_gen_in,
    input  wire logic [apl_pkg::NUM_AXES-1:0]               i_index,
    input  wire logic [apl_pkg::NUM_AXES-1:0][apl_pkg::POS_W-1:0] i_main_pos,
    input  wire logic [apl_pkg::NUM_AXES-1:0][apl_pkg::POS_W-1:0] i_aux_pos,
    input  wire logic [apl_pkg::NUM_AXES-1:0]               i_sampled_fb,
    input  wire logic                                       i_arm_capture_cmd,
    input  wire logic                                       i_report_capture_cmd,
    input  wire logic [apl_pkg::AXIS_W-1:0]                 i_cmd_axis,
    input  wire logic                                       i_trig_sel,
    input  wire logic                                       i_enc_sel,
    output logic                                            o_arm_refused,
    output logic                                            o_report_valid,
    output logic [apl_pkg::POS_W-1:0]                       o_report_pos,
    output logic                                            o_report_armed,
    output logic                                            o_report_captured,
    output logic [apl_pkg::NUM_AXES-1:0]                    o_armed,
    output logic [apl_pkg::NUM_AXES-1:0]                    o_captured
);
    import apl_pkg::*;

    // general input bit that serves as the latch input of an axis
    // inputs 5 to 8 carry no axis and are never routed to a unit
    function automatic int latch_bit(input int axis);
        latch_bit = (axis < HIGH_AXIS_LO) ? axis : axis + HIGH_IN_OFS;
    endfunction : latch_bit

    // one-hot decode of the command axis
    function automatic logic [NUM_AXES-1:0] axis_hot(input logic [AXIS_W-1:0] axis);
        axis_hot = '0;
        axis_hot[axis] = 1'b1;
    endfunction : axis_hot

    // pin side: every asynchronous pin passes two flip-flops, and a third keeps
    // the previous level for edge finding; nothing but stage two reads stage one
    logic [NUM_GEN_IN-1:0] gen_s1_ff;      // first synchroniser stage, read only by stage two
    logic [NUM_GEN_IN-1:0] gen_s2_ff;      // synchronised general inputs
    logic [NUM_GEN_IN-1:0] gen_prev_ff;    // previous synchronised level
    logic [NUM_AXES-1:0]   idx_s1_ff;      // first stage of index synchroniser
    logic [NUM_AXES-1:0]   idx_s2_ff;      // synchronised index
    logic [NUM_AXES-1:0]   idx_prev_ff;    // previous synchronised index
    logic [NUM_GEN_IN-1:0] gen_fall;       // falling edges of general inputs
    logic [NUM_AXES-1:0]   idx_fall;       // falling edges of index pulses
    logic [NUM_AXES-1:0]   cmd_hot;        // decoded command axis
    logic [NUM_AXES-1:0]   arm_vec;        // accepted arm, per axis
    logic                  arm_bad;        // arm aimed at a sampled feedback axis
    logic [NUM_AXES-1:0][POS_W-1:0] cap_pos;  // held positions gathered from units

    logic                  report_valid_ff;     // report answer strobe
    logic [POS_W-1:0]      report_pos_ff;       // reported position
    logic                  report_armed_ff;     // reported armed status
    logic                  report_captured_ff;  // reported captured status
    logic                  arm_refused_ff;      // refused arm strobe

    // two-stage synchronisers; inputs idle high so reset to ones
    // resetting to the idle level keeps a false fall from following reset
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gen_s1_ff   <= '1;
            gen_s2_ff   <= '1;
            gen_prev_ff <= '1;
            idx_s1_ff   <= '1;
            idx_s2_ff   <= '1;
            idx_prev_ff <= '1;
        end else begin
            gen_s1_ff   <= i_gen_in;
            gen_s2_ff   <= gen_s1_ff;
            gen_prev_ff <= gen_s2_ff;
            idx_s1_ff   <= i_index;
            idx_s2_ff   <= idx_s1_ff;
            idx_prev_ff <= idx_s2_ff;
        end
    end

    // only high-to-low changes make a trigger; a rise is dropped here,
    // so a source that idles low and pulses high is caught only on the
    // trailing fall of its pulse
    assign gen_fall = gen_prev_ff & ~gen_s2_ff;
    assign idx_fall = idx_prev_ff & ~idx_s2_ff;

    // command decode; a sampled feedback axis refuses arming
    // an arm and a report in one cycle both act on the same axis
    assign cmd_hot = axis_hot(i_cmd_axis);
    assign arm_bad = i_arm_capture_cmd && i_sampled_fb[i_cmd_axis];
    assign arm_vec = (i_arm_capture_cmd && !arm_bad) ? cmd_hot : '0;

    // one capture unit per axis, each on its fixed latch input
    // all units share the trigger and encoder choice lines; only the armed
    // unit latches them, so a later command for another axis leaves this
    // one alone
    for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
        apl_cap_if u_cap ();

        assign u_cap.arm      = arm_vec[g];
        assign u_cap.trig_sel = i_trig_sel;
        assign u_cap.enc_sel  = i_enc_sel;
        assign u_cap.sampled  = i_sampled_fb[g];
        assign u_cap.lat_fall = gen_fall[latch_bit(g)];
        assign u_cap.idx_fall = idx_fall[g];
        assign u_cap.main_pos = i_main_pos[g];
        assign u_cap.aux_pos  = i_aux_pos[g];
        assign o_armed[g]     = u_cap.armed;
        assign o_captured[g]  = u_cap.captured;
        assign cap_pos[g]     = u_cap.cap_pos;

        apl_axis_unit u_unit (
            .i_clk     (i_clk),
            .i_sys_rst (i_sys_rst),
            .cap       (u_cap.unit)
        );
    end

    // report answers one cycle after the command with the held position
    // the status is taken at the same edge as the position, so the three
    // answers always describe one moment; a capture in that very edge
    // shows up only in the next report
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            report_valid_ff    <= 1'b0;
            report_pos_ff      <= POS_RST;
            report_armed_ff    <= 1'b0;
            report_captured_ff <= 1'b0;
        end else begin
            report_valid_ff <= i_report_capture_cmd;
            if (i_report_capture_cmd) begin
                report_pos_ff      <= cap_pos[i_cmd_axis];
                report_armed_ff    <= o_armed[i_cmd_axis];
                report_captured_ff <= o_captured[i_cmd_axis];
            end
        end
    end

    // refused arm is flagged for one cycle
    // an arm aimed at a sampled feedback axis changes nothing else
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            arm_refused_ff <= 1'b0;
        end else begin
            arm_refused_ff <= arm_bad;
        end
    end

    // every report and refusal output comes straight from a flip-flop
    assign o_report_valid    = report_valid_ff;
    assign o_report_pos      = report_pos_ff;
    assign o_report_armed    = report_armed_ff;
    assign o_report_captured = report_captured_ff;
    assign o_arm_refused     = arm_refused_ff;

    // latency watch on axis A: cycles since its synchronised latch fall while
    // it is armed on that input; the watch restarts on every arm of axis A, because an
    // arm in the capture cycle drops the event and starts a fresh wait
    // the budget assertion below reads this counter
    logic [LAT_CNT_W-1:0] lat_cnt_ff;     // cycles since the fall was seen
    logic                 lat_mode_a_ff;  // axis A armed on its latch input
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lat_cnt_ff    <= '0;
            lat_mode_a_ff <= 1'b0;
        end else if (!o_armed[0] || arm_vec[0]) begin
            // idle, captured or freshly armed: nothing is pending
            lat_cnt_ff    <= '0;
            lat_mode_a_ff <= arm_vec[0] && (i_trig_sel == TRIG_LATCH);
        end else if (lat_cnt_ff != '0 || (lat_mode_a_ff && gen_fall[0])) begin
            // a fall is pending; only the synchronised level is read
            lat_cnt_ff <= lat_cnt_ff + LAT_CNT_W'(1);
        end
    end

    // axis A waits on its latch input
    sequence s_arm_a_latch;
        o_armed[0] && lat_mode_a_ff;
    endsequence
    // a fall on general input b while axis a stays armed and undisturbed
    sequence s_fall_on(int b, int a);
        !i_arm_capture_cmd && o_armed[a] && !i_sampled_fb[a] && $fell(i_gen_in[b]);
    endsequence
    // axis A neither re-armed nor dropped by the sampled feedback flag
    sequence s_quiet_a;
        !i_arm_capture_cmd && !i_sampled_fb[0];
    endsequence

    // pin low at the first sampling edge, captured three edges later
    AST_LATENCY_A: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (s_arm_a_latch ##0 s_fall_on(0, 0) ##1 s_quiet_a[*2]) |=> o_captured[0])
        else $error("axis A capture missed its latency");
    // input nine reaches axis E: after four quiet edges E holds a position
    AST_MAP_E: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (s_fall_on(8, 4) ##1 (!i_arm_capture_cmd && !i_sampled_fb[4] && o_armed[4])[*2]
         ##1 (g_axis[4].u_unit.trig_sel_ff == TRIG_LATCH && !i_arm_capture_cmd && !i_sampled_fb[4]))
        |=> o_captured[4])
        else $error("input nine did not capture axis E");
    AST_LAT_BUDGET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        lat_cnt_ff < LAT_CNT_W'(P_LAT_CYC))
        else $error("axis A latency budget exceeded");
    AST_REPORT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_report_capture_cmd |=> (o_report_valid && o_report_pos == $past(cap_pos[i_cmd_axis])))
        else $error("report answer wrong or late");
    AST_ARM_REFUSE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_arm_capture_cmd && i_sampled_fb[i_cmd_axis]) |=> (o_arm_refused && !o_armed[$past(i_cmd_axis)]))
        else $error("sampled feedback axis accepted an arm");
    // the report carries the status of the asked axis as it stood when taken
    AST_REPORT_STATUS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_report_capture_cmd |=> (o_report_armed == $past(o_armed[i_cmd_axis]) &&
                                  o_report_captured == $past(o_captured[i_cmd_axis])))
        else $error("report status does not match the asked axis");
    // the report strobe lasts one cycle and its data stands until the next report
    AST_REPORT_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_report_capture_cmd |=> (!o_report_valid && $stable(o_report_pos)))
        else $error("report answer changed without a report command");
    // a refusal strobe only follows a refused arm
    AST_REFUSE_PULSE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !(i_arm_capture_cmd && i_sampled_fb[i_cmd_axis]) |=> !o_arm_refused)
        else $error("arm refusal without a refused arm");
endmodule : apl_position_latch

// >>> core/apl_pkg.sv
// constants, types and state encoding for the per-axis position latch
// assumes one 250 MHz clock; encoder counters run in that same clock domain
package apl_pkg;
    localparam int NUM_AXES     = 8;            // axes A..H
    localparam int NUM_GEN_IN   = 12;           // general inputs 1..12 on bits 0..11
    localparam int POS_W        = 32;           // encoder position width
    localparam int AXIS_W       = 3;            // axis number width
    localparam int HIGH_AXIS_LO = 4;            // first axis (E) of the upper group
    localparam int HIGH_IN_OFS  = 4;            // axis E..H use input bits 8..11
    localparam int CLK_MHZ      = 250;          // clock rate
    localparam int LAT_US       = 25;           // longest capture latency, microseconds
    localparam int LAT_CYC      = LAT_US * CLK_MHZ;  // longest latency in cycles, 6250
    localparam int LAT_CNT_W    = 14;           // width of the latency watch counter

    localparam logic TRIG_LATCH = 1'b0;         // trigger on the axis latch input
    localparam logic TRIG_INDEX = 1'b1;         // trigger on the axis index pulse
    localparam logic ENC_MAIN   = 1'b0;         // capture the main encoder
    localparam logic ENC_AUX    = 1'b1;         // capture the auxiliary encoder

    localparam logic [POS_W-1:0] POS_RST  = 32'h0000_0000;  // captured position after reset
    localparam logic [1:0]       SYNC_RST = 2'h3;            // pins idle high

    // per-axis capture state
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_DONE
    } apl_state_t;
endpackage : apl_pkg

// >>> core/apl_cap_if.sv
// carrier between the position latch top and one per-axis capture unit
// assumes all signals are on the single controller clock
`timescale 1ns/1ps
interface apl_cap_if;
    import apl_pkg::*;
    logic             arm;        // one-cycle arm request
    logic             trig_sel;   // trigger source for this arming
    logic             enc_sel;    // encoder to capture for this arming
    logic             sampled;    // axis uses sampled feedback
    logic             lat_fall;   // falling edge seen on the latch input
    logic             idx_fall;   // falling edge seen on the index pulse
    logic [POS_W-1:0] main_pos;   // main encoder count
    logic [POS_W-1:0] aux_pos;    // auxiliary encoder count
    logic             armed;      // waiting for a trigger
    logic             captured;   // position held
    logic [POS_W-1:0] cap_pos;    // held position

    modport ctl (output arm, trig_sel, enc_sel, sampled, lat_fall, idx_fall, main_pos, aux_pos,
                 input armed, captured, cap_pos);
    modport unit (input arm, trig_sel, enc_sel, sampled, lat_fall, idx_fall, main_pos, aux_pos,
                  output armed, captured, cap_pos);
endinterface : apl_cap_if

// >>> core/apl_axis_unit.sv
// single-shot capture unit for one axis
// assumes edge pulses are already synchronised and one cycle long
`timescale 1ns/1ps
module apl_axis_unit (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    apl_cap_if.unit   cap
);
    import apl_pkg::*;

    apl_state_t       state_ff;      // capture state
    apl_state_t       nxt_state;     // next capture state
    logic             trig_sel_ff;   // trigger source held from arming
    logic             enc_sel_ff;    // encoder choice held from arming
    logic [POS_W-1:0] pos_ff;        // captured position
    logic             fire;          // selected trigger fell while armed
    logic [POS_W-1:0] src_pos;       // position chosen for capture

    // only falling edges reach here; rising edges never fire
    assign fire    = (state_ff == ST_ARMED) &&
                     ((trig_sel_ff == TRIG_INDEX) ? cap.idx_fall : cap.lat_fall);
    assign src_pos = (enc_sel_ff == ENC_AUX) ? cap.aux_pos : cap.main_pos;

    // sampled feedback kills capture; arm beats a same-cycle trigger
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:  nxt_state = ST_IDLE;
            ST_ARMED: if (fire) begin
                nxt_state = ST_DONE;
            end
            ST_DONE:  nxt_state = ST_DONE;
            default:  nxt_state = ST_IDLE;
        endcase
        if (cap.arm) begin
            nxt_state = ST_ARMED;
        end
        if (cap.sampled) begin
            nxt_state = ST_IDLE;
        end
    end

    // state and configuration registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff    <= ST_IDLE;
            trig_sel_ff <= TRIG_LATCH;
            enc_sel_ff  <= ENC_MAIN;
        end else begin
            state_ff <= nxt_state;
            if (cap.arm) begin
                trig_sel_ff <= cap.trig_sel;
                enc_sel_ff  <= cap.enc_sel;
            end
        end
    end

    // the snapshot is taken on the edge the trigger is seen
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pos_ff <= POS_RST;
        end else if (fire && !cap.arm && !cap.sampled) begin
            pos_ff <= src_pos;
        end
    end

    assign cap.armed    = (state_ff == ST_ARMED);
    assign cap.captured = (state_ff == ST_DONE);
    assign cap.cap_pos  = pos_ff;

    AST_ONE_SHOT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (cap.captured && !cap.arm && !cap.sampled) |=> (cap.captured && $stable(pos_ff)))
        else $error("capture changed without re-arming");
    AST_CAPTURE_SRC: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(cap.captured) |-> (pos_ff == $past(src_pos)))
        else $error("captured position is not the selected encoder");
    AST_TRIG_SEL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(cap.captured) |-> $past((trig_sel_ff == TRIG_INDEX) ? cap.idx_fall : cap.lat_fall))
        else $error("capture without a fall of the selected trigger");
    AST_ARM_STATUS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (cap.arm && !cap.sampled) |=> (cap.armed && !cap.captured))
        else $error("status not armed after arming");
    AST_NO_SAMPLED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        cap.sampled |=> (!cap.armed && !cap.captured))
        else $error("sampled feedback axis still armed or captured");
endmodule : apl_axis_unit

// >>> testbench/apl_far_side.sv
// far-side model: general input pins, index pins and encoder counts
// assumes one bench thread calls its tasks; pins idle high like real pull-ups
`timescale 1ns/1ps
module apl_far_side (
    input  wire logic                                             i_clk,
    output logic [apl_pkg::NUM_GEN_IN-1:0]                        o_gen_in,
    output logic [apl_pkg::NUM_AXES-1:0]                          o_index,
    output logic [apl_pkg::NUM_AXES-1:0][apl_pkg::POS_W-1:0]      o_main_pos,
    output logic [apl_pkg::NUM_AXES-1:0][apl_pkg::POS_W-1:0]      o_aux_pos
);
    import apl_pkg::*;

    // pins rest high, counts start at zero
    initial begin
        o_gen_in   = '1;
        o_index    = '1;
        o_main_pos = '0;
        o_aux_pos  = '0;
    end

    // load both counts of one axis just after an edge; held still so a capture is exact
    task automatic set_pos(input int ax, input logic [POS_W-1:0] m, input logic [POS_W-1:0] a);
        @(posedge i_clk);
        #1;
        o_main_pos[ax] = m;
        o_aux_pos[ax]  = a;
    endtask : set_pos

    // drive one pin and hold it four cycles, longer than the three the synchroniser needs
    task automatic pin(input logic is_idx, input int b, input logic v);
        @(posedge i_clk);
        #1;
        if (is_idx) begin
            o_index[b] = v;
        end else begin
            o_gen_in[b] = v;
        end
        repeat (4) @(posedge i_clk);
        // return off the edge so the caller's next change stays clear of it
        #1;
    endtask : pin

    // one event signalled as a high-to-low transition, then back to rest
    task automatic pulse(input logic is_idx, input int b);
        pin(is_idx, b, 1'b0);
        pin(is_idx, b, 1'b1);
    endtask : pulse
endmodule : apl_far_side

// >>> testbench/axis_position_latch_bench.sv
// self-checking bench for the eight-axis position latch
// assumes the far-side model drives all pins and counts; bench drives commands
`timescale 1ns/1ps
module axis_position_latch_bench;
    import apl_pkg::*;

    logic                              clk = 1'b0;      // 250 MHz
    logic                              rst = 1'b1;      // async, active high
    logic [NUM_GEN_IN-1:0]             gen_in;          // from model
    logic [NUM_AXES-1:0]               index;           // from model
    logic [NUM_AXES-1:0][POS_W-1:0]    main_pos;        // from model
    logic [NUM_AXES-1:0][POS_W-1:0]    aux_pos;         // from model
    logic [NUM_AXES-1:0]               sampled = '0;    // feedback kind per axis
    logic                              arm = 1'b0;      // arm pulse
    logic                              rep = 1'b0;      // report pulse
    logic [AXIS_W-1:0]                 ax_sel = '0;     // command axis
    logic                              trig = 1'b0;     // trigger source
    logic                              enc = 1'b0;      // encoder choice
    logic                              refused;
    logic                              rvalid;
    logic [POS_W-1:0]                  rpos;
    logic                              rarmed;
    logic                              rcapt;
    logic [NUM_AXES-1:0]               armed;
    logic [NUM_AXES-1:0]               capt;
    int                                fail_count = 0;
    int                                compares = 0;
    int                                cycles = 0;

    apl_far_side far (.i_clk(clk), .o_gen_in(gen_in), .o_index(index), .o_main_pos(main_pos),
                      .o_aux_pos(aux_pos));

    // short latency budget keeps the design's own watch counter quick
    apl_position_latch #(.P_LAT_CYC(16)) dut (
        .i_clk(clk), .i_sys_rst(rst), .i_gen_in(gen_in), .i_index(index), .i_main_pos(main_pos),
        .i_aux_pos(aux_pos), .i_sampled_fb(sampled), .i_arm_capture_cmd(arm),
        .i_report_capture_cmd(rep), .i_cmd_axis(ax_sel), .i_trig_sel(trig), .i_enc_sel(enc),
        .o_arm_refused(refused), .o_report_valid(rvalid), .o_report_pos(rpos),
        .o_report_armed(rarmed), .o_report_captured(rcapt), .o_armed(armed), .o_captured(capt));

    // clock
    initial begin
        forever #2 clk = ~clk;
    end

    // hang guard: the whole run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end

    // one comparison, four-state exact
    task automatic chk(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    // one-cycle command; outputs of the taking edge are settled on return
    task automatic cmd(input logic a, input logic r, input int ax, input logic t, input logic e);
        @(posedge clk);
        #1;
        arm    = a;
        rep    = r;
        ax_sel = AXIS_W'(ax);
        trig   = t;
        enc    = e;
        @(posedge clk);
        #1;
        arm = 1'b0;
        rep = 1'b0;
    endtask : cmd

    // report one axis and compare the answer
    task automatic report(input int ax, input logic [POS_W-1:0] p, input logic a, input logic c);
        cmd(1'b0, 1'b1, ax, 1'b0, 1'b0);
        chk(rvalid, 1, "report valid");
        chk(rpos, p, "report position");
        chk(rarmed, a, "report armed");
        chk(rcapt, c, "report captured");
    endtask : report

    // fall on a pin, then check capture landed within the four edges it is held; the model
    // returns one step after an edge, so the outputs are settled here
    task automatic fall_capture(input logic is_idx, input int b, input int ax);
        far.pin(is_idx, b, 1'b0);
        chk(capt[ax], 1, "captured after fall");
        chk(armed[ax], 0, "armed cleared on capture");
        far.pin(is_idx, b, 1'b1);
    endtask : fall_capture

    // status and report are clear after reset
    task automatic t_reset;
        chk(armed, 0, "armed after reset");
        chk(capt, 0, "captured after reset");
        chk(rvalid, 0, "report valid after reset");
        chk(refused, 0, "arm refused after reset");
        report(7, 0, 0, 0);
    endtask : t_reset

    // every axis on its own fixed input, main and aux alternating
    task automatic t_axes;
        int b;
        logic [POS_W-1:0] m;
        logic [POS_W-1:0] a;
        for (int ax = 0; ax < NUM_AXES; ax++) begin
            b = (ax < HIGH_AXIS_LO) ? ax : ax + HIGH_IN_OFS;
            m = 32'h1000_0000 + 32'(ax) * 32'h0000_0111;
            a = 32'h2000_0000 + 32'(ax) * 32'h0000_0222;
            far.set_pos(ax, m, a);
            cmd(1'b1, 1'b0, ax, TRIG_LATCH, 1'(ax));
            chk(armed[ax], 1, "armed after arm");
            fall_capture(1'b0, b, ax);
            report(ax, ax[0] ? a : m, 0, 1);
        end
    endtask : t_axes

    // one capture per arming; a re-arm takes the new count
    task automatic t_single;
        far.set_pos(0, 32'h3000_00aa, 32'h0);
        far.pulse(1'b0, 0);
        report(0, 32'h1000_0000, 0, 1);
        cmd(1'b1, 1'b0, 0, TRIG_LATCH, ENC_MAIN);
        fall_capture(1'b0, 0, 0);
        report(0, 32'h3000_00aa, 0, 1);
    endtask : t_single

    // other pins never trigger axis A; an armed axis reports armed
    task automatic t_wrong_pin;
        cmd(1'b1, 1'b0, 0, TRIG_LATCH, ENC_MAIN);
        report(0, 32'h3000_00aa, 1, 0);
        far.pulse(1'b0, 4);
        far.pulse(1'b0, 8);
        far.pulse(1'b0, 1);
        far.pulse(1'b1, 0);
        chk(capt[0], 0, "foreign pin captured");
        fall_capture(1'b0, 0, 0);
    endtask : t_wrong_pin

    // index source ignores the latch input
    task automatic t_index;
        far.set_pos(2, 32'h4000_0002, 32'h5000_0002);
        cmd(1'b1, 1'b0, 2, TRIG_INDEX, ENC_AUX);
        far.pulse(1'b0, 2);
        chk(capt[2], 0, "latch pin used in index mode");
        fall_capture(1'b1, 2, 2);
        report(2, 32'h5000_0002, 0, 1);
    endtask : t_index

    // a rising transition does not capture
    task automatic t_rising;
        far.pin(1'b0, 3, 1'b0);
        cmd(1'b1, 1'b0, 3, TRIG_LATCH, ENC_MAIN);
        far.pin(1'b0, 3, 1'b1);
        repeat (8) @(posedge clk);
        #1;
        chk(capt[3], 0, "rising edge captured");
        fall_capture(1'b0, 3, 3);
    endtask : t_rising

    // sampled feedback refuses arming and drops an armed axis
    task automatic t_sampled;
        sampled[5] = 1'b1;
        cmd(1'b1, 1'b0, 5, TRIG_LATCH, ENC_MAIN);
        chk(refused, 1, "arm refusal pulse");
        chk(armed[5], 0, "sampled axis armed");
        @(posedge clk);
        #1;
        chk(refused, 0, "arm refusal longer than one cycle");
        far.pulse(1'b0, 9);
        chk(capt[5], 0, "sampled axis captured");
        sampled[5] = 1'b0;
        cmd(1'b1, 1'b0, 5, TRIG_LATCH, ENC_MAIN);
        chk(armed[5], 1, "rearm after sampled cleared");
        sampled[5] = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(armed[5], 0, "sampled flag drops armed axis");
        sampled[5] = 1'b0;
    endtask : t_sampled

    // counts, verdict, end of run
    task automatic summarize;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // reset for four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_axes();
        t_single();
        t_wrong_pin();
        t_index();
        t_rising();
        t_sampled();
        summarize();
    end
endmodule : axis_position_latch_bench
